// ---- hdl/spdp_pkg.sv ----
`default_nettype none
package spdp_pkg;
	// Command opcodes.
	localparam logic [7:0] OP_DISABLE_PW  = 8'hf6;
	localparam logic [7:0] OP_ERASE_PREP  = 8'hf3;
	localparam logic [7:0] OP_ERASE_UNIT  = 8'hf4;
	localparam logic [7:0] OP_SET_PW      = 8'hf1;
	localparam logic [7:0] OP_UNLOCK      = 8'hf2;
	// Sector layout in 16-bit words.
	localparam int         SECTOR_WORDS   = 256;
	localparam int         PW_FIRST_WORD  = 1;
	localparam int         PW_LAST_WORD   = 16;
	localparam int         PW_WORDS       = 16;
	localparam int         SEL_BIT        = 0;
	localparam logic [8:0] LAST_WORD_IDX  = 9'h0ff;
	// Error byte layout.
	localparam int         ERR_ABORT_BIT  = 2;
	localparam logic [7:0] ERR_ABORT      = 8'h04;
	localparam logic [7:0] ERR_NONE       = 8'h00;
	// Status byte layout: busy, ready, seek complete, data request, error.
	localparam logic [7:0] STS_RDY_DSC    = 8'h50;
	localparam logic [7:0] STS_ERR        = 8'h01;
	localparam logic [7:0] STS_DRQ        = 8'h08;
	localparam logic [7:0] STS_BSY        = 8'h80;
endpackage
`default_nettype wire

// ---- hdl/spdp_if.sv ----
`default_nettype none
interface spdp_if;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic        data_req;
	logic        data_valid;
	logic [15:0] data_word;
	logic        done;
	logic [7:0]  status;
	logic [7:0]  error;
	logic        busy;

	modport dev  (input cmd_valid, cmd_code, data_valid, data_word,
		output data_req, done, status, error, busy);
	modport host (output cmd_valid, cmd_code, data_valid, data_word,
		input data_req, done, status, error, busy);
endinterface
`default_nettype wire

// ---- hdl/spdp_device.sv ----
`default_nettype none
module spdp_device #(
	parameter int PW_BITS = 256
) (
	input  wire logic               ref_clk_i,
	input  wire logic               srst_i,
	spdp_if.dev                     link,
	input  wire logic               lock_enabled_i,
	input  wire logic               frozen_i,
	input  wire logic [PW_BITS-1:0] user_pw_i,
	input  wire logic [PW_BITS-1:0] master_pw_i,
	output logic                    lock_clear_o,
	output logic                    erase_start_o,
	output logic                    prepared_o
);
	typedef enum logic [1:0] {
		SPDP_IDLE = 2'b00,
		SPDP_XFER = 2'b01,
		SPDP_CHK  = 2'b10,
		SPDP_DONE = 2'b11
	} spdp_state_t;

	spdp_state_t          state_reg, state_next;
	logic [8:0]           idx_reg, idx_next;
	logic                 sel_reg, sel_next;
	logic [PW_BITS-1:0]   pw_reg, pw_next;
	logic                 armed_reg, armed_next;
	logic                 done_reg, done_next;
	logic [7:0]           status_reg, status_next;
	logic [7:0]           error_reg, error_next;
	logic                 clr_reg, clr_next;
	logic                 erase_reg, erase_next;
	logic                 req_reg, req_next;
	logic                 busy_reg, busy_next;

	// Finish a command: set ending status, aborted or good.
	function automatic logic [15:0] spdp_end(input logic abort);
		spdp_end = abort ? {spdp_pkg::STS_RDY_DSC | spdp_pkg::STS_ERR, spdp_pkg::ERR_ABORT}
			: {spdp_pkg::STS_RDY_DSC, spdp_pkg::ERR_NONE};
	endfunction

	// Next-state logic. The password is kept as plain flops because one sector is small.
	always_comb
	begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		sel_next    = sel_reg;
		pw_next     = pw_reg;
		armed_next  = armed_reg;
		done_next   = 1'b0;
		status_next = status_reg;
		error_next  = error_reg;
		clr_next    = 1'b0;
		erase_next  = 1'b0;
		case (state_reg)
			SPDP_IDLE:
			begin
				if (link.cmd_valid)
				begin
					armed_next = 1'b0;
					case (link.cmd_code)
						spdp_pkg::OP_DISABLE_PW:
						begin
							if (frozen_i)
							begin
								{status_next, error_next} = spdp_end(1'b1);
								state_next = SPDP_DONE;
							end
							else
							begin
								idx_next    = '0;
								status_next = spdp_pkg::STS_RDY_DSC | spdp_pkg::STS_DRQ;
								error_next  = spdp_pkg::ERR_NONE;
								state_next  = SPDP_XFER;
							end
						end
						spdp_pkg::OP_ERASE_PREP:
						begin
							armed_next = !frozen_i;
							{status_next, error_next} = spdp_end(frozen_i);
							state_next = SPDP_DONE;
						end
						spdp_pkg::OP_ERASE_UNIT:
						begin
							// Only the ordering gate lives here; the erase engine is elsewhere.
							erase_next = armed_reg && !frozen_i;
							{status_next, error_next} = spdp_end(!armed_reg || frozen_i);
							state_next = SPDP_DONE;
						end
						default:
						begin
							{status_next, error_next} = spdp_end(1'b1);
							state_next = SPDP_DONE;
						end
					endcase
				end
			end
			SPDP_XFER:
			begin
				if (link.data_valid)
				begin
					// Word 0 is control, words 1..16 password, the rest ignored.
					if (idx_reg == 9'h000)
						sel_next = link.data_word[spdp_pkg::SEL_BIT];
					else if (idx_reg <= 9'(spdp_pkg::PW_LAST_WORD))
						pw_next = {link.data_word, pw_reg[PW_BITS-1:16]};
					idx_next = idx_reg + 9'h001;
					if (idx_reg == spdp_pkg::LAST_WORD_IDX)
					begin
						status_next = spdp_pkg::STS_BSY;
						state_next  = SPDP_CHK;
					end
				end
			end
			SPDP_CHK:
			begin
				// Only the selected password is compared; master is only read.
				if (!lock_enabled_i && !sel_reg)
					{status_next, error_next} = spdp_end(1'b1);
				else if (pw_reg == (sel_reg ? master_pw_i : user_pw_i))
				begin
					clr_next = 1'b1;
					{status_next, error_next} = spdp_end(1'b0);
				end
				else
					{status_next, error_next} = spdp_end(1'b1);
				state_next = SPDP_DONE;
			end
			SPDP_DONE:
			begin
				done_next  = 1'b1;
				state_next = SPDP_IDLE;
			end
			default: state_next = SPDP_IDLE;
		endcase
		// Handshake levels follow the next state so that they leave straight from flops.
		req_next  = state_next == SPDP_XFER;
		busy_next = state_next != SPDP_IDLE;
	end

	// Registers.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			req_reg    <= 1'b0;
			busy_reg   <= 1'b0;
			state_reg  <= SPDP_IDLE;
			idx_reg    <= '0;
			sel_reg    <= 1'b0;
			pw_reg     <= '0;
			armed_reg  <= 1'b0;
			done_reg   <= 1'b0;
			status_reg <= spdp_pkg::STS_RDY_DSC;
			error_reg  <= spdp_pkg::ERR_NONE;
			clr_reg    <= 1'b0;
			erase_reg  <= 1'b0;
		end
		else
		begin
			req_reg    <= req_next;
			busy_reg   <= busy_next;
			state_reg  <= state_next;
			idx_reg    <= idx_next;
			sel_reg    <= sel_next;
			pw_reg     <= pw_next;
			armed_reg  <= armed_next;
			done_reg   <= done_next;
			status_reg <= status_next;
			error_reg  <= error_next;
			clr_reg    <= clr_next;
			erase_reg  <= erase_next;
		end
	end

	// Every output is taken straight from a flop, so the host never sees decode glitches.
	assign link.data_req = req_reg;
	assign link.busy     = busy_reg;
	assign link.done     = done_reg;
	assign link.status   = status_reg;
	assign link.error    = error_reg;
	assign lock_clear_o  = clr_reg;
	assign erase_start_o = erase_reg;
	assign prepared_o    = armed_reg;
endmodule
`default_nettype wire

// ---- hdl/spdp_host.sv ----
`default_nettype none
module spdp_host #(
	parameter int PW_BITS = 256
) (
	input  wire logic               ref_clk_i,
	input  wire logic               srst_i,
	spdp_if.host                    link,
	input  wire logic               req_i,
	input  wire logic [7:0]         req_code_i,
	input  wire logic               req_master_i,
	input  wire logic [PW_BITS-1:0] req_pw_i,
	output logic                    ack_o,
	output logic                    aborted_o,
	output logic [7:0]              status_o
);
	typedef enum logic [1:0] {
		SPDH_IDLE = 2'b00,
		SPDH_WAIT = 2'b01,
		SPDH_SEND = 2'b10
	} spdp_host_state_t;

	spdp_host_state_t   state_reg, state_next;
	logic [8:0]         idx_reg, idx_next;
	logic [7:0]         code_reg, code_next;
	logic [PW_BITS-1:0] pw_reg, pw_next;
	logic               sel_reg, sel_next;
	logic               ack_reg, ack_next;
	logic               abt_reg, abt_next;
	logic [7:0]         sts_reg, sts_next;
	logic               cv_reg, cv_next;
	logic               dv_reg, dv_next;
	logic [15:0]        dw_reg, dw_next;

	// Issue one command; for disable supply the sector word by word. Issuing
	// erase-prepare right before erase-unit is up to the user's ordering.
	always_comb
	begin
		state_next = state_reg;
		idx_next   = idx_reg;
		code_next  = code_reg;
		pw_next    = pw_reg;
		sel_next   = sel_reg;
		ack_next   = 1'b0;
		abt_next   = abt_reg;
		sts_next   = sts_reg;
		cv_next    = 1'b0;
		dv_next    = 1'b0;
		dw_next    = dw_reg;
		case (state_reg)
			SPDH_IDLE:
			begin
				if (req_i && !link.busy)
				begin
					code_next  = req_code_i;
					pw_next    = req_pw_i;
					sel_next   = req_master_i;
					idx_next   = '0;
					cv_next    = 1'b1;
					state_next = SPDH_WAIT;
				end
			end
			SPDH_WAIT:
			begin
				// The request is still seen one edge after the last word; only an unsent sector starts a send.
				if (link.data_req && idx_reg == 9'h000)
					state_next = SPDH_SEND;
				else if (link.done)
				begin
					ack_next   = 1'b1;
					abt_next   = link.error[spdp_pkg::ERR_ABORT_BIT];
					sts_next   = link.status;
					state_next = SPDH_IDLE;
				end
			end
			SPDH_SEND:
			begin
				// Control word, then password low word first, then zero fill.
				dv_next = 1'b1;
				if (idx_reg == 9'h000)
					dw_next = {15'h0000, sel_reg};
				else if (idx_reg <= 9'(spdp_pkg::PW_LAST_WORD))
				begin
					dw_next = pw_reg[15:0];
					pw_next = pw_reg >> 16;
				end
				else
					dw_next = 16'h0000;
				idx_next = idx_reg + 9'h001;
				if (idx_reg == spdp_pkg::LAST_WORD_IDX)
					state_next = SPDH_WAIT;
			end
			default: state_next = SPDH_IDLE;
		endcase
	end

	// Registers.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			state_reg <= SPDH_IDLE;
			idx_reg   <= '0;
			code_reg  <= 8'h00;
			pw_reg    <= '0;
			sel_reg   <= 1'b0;
			ack_reg   <= 1'b0;
			abt_reg   <= 1'b0;
			sts_reg   <= 8'h00;
			cv_reg    <= 1'b0;
			dv_reg    <= 1'b0;
			dw_reg    <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			code_reg  <= code_next;
			pw_reg    <= pw_next;
			sel_reg   <= sel_next;
			ack_reg   <= ack_next;
			abt_reg   <= abt_next;
			sts_reg   <= sts_next;
			cv_reg    <= cv_next;
			dv_reg    <= dv_next;
			dw_reg    <= dw_next;
		end
	end

	assign link.cmd_valid  = cv_reg;
	assign link.cmd_code   = code_reg;
	assign link.data_valid = dv_reg;
	assign link.data_word  = dw_reg;
	assign ack_o           = ack_reg;
	assign aborted_o       = abt_reg;
	assign status_o        = sts_reg;
endmodule
`default_nettype wire

// ---- verif/spdp_monitor.sv ----
`default_nettype none
// Watches the link between the two ends on every rising clock edge.
module spdp_monitor (
	input wire logic        ref_clk_i,
	input wire logic        srst_i,
	input wire logic        frozen_i,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        data_req,
	input wire logic        data_valid,
	input wire logic [15:0] data_word,
	input wire logic        done,
	input wire logic [7:0]  status,
	input wire logic [7:0]  error,
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	logic       take;
	logic [8:0] words_reg;
	logic [7:0] cur_reg;
	logic [7:0] prev_reg;
	assign take = cmd_valid && !busy;
	// Word count and last two opcodes; an erase-unit counts as prepared only right after a prepare.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i || take)
			words_reg <= 9'h000;
		else if (data_valid && data_req)
			words_reg <= words_reg + 9'h001;
		if (srst_i)
		begin
			cur_reg  <= 8'h00;
			prev_reg <= 8'h00;
		end
		else if (take)
		begin
			cur_reg  <= cmd_code;
			prev_reg <= cur_reg;
		end
	end
	f3_no_data_a: assert property (take && cmd_code == spdp_pkg::OP_ERASE_PREP |=> !data_req ##1 done && !data_req)
		else $error("prepare did not end cleanly in two cycles");
	f6_sector_req_a: assert property (take && !frozen_i && cmd_code == spdp_pkg::OP_DISABLE_PW |=> data_req)
		else $error("disable did not ask for data");
	frozen_refuse_a: assert property (take && frozen_i && (cmd_code == spdp_pkg::OP_DISABLE_PW
		|| cmd_code == spdp_pkg::OP_ERASE_UNIT) |=> !data_req ##1 done && error == spdp_pkg::ERR_ABORT)
		else $error("frozen device did not refuse a lock command");
	sector_length_a: assert property ($fell(data_req) |-> words_reg == 9'h100)
		else $error("sector was not 256 words");
	req_hold_a: assert property (data_req && !data_valid |=> data_req)
		else $error("data request dropped early");
	f6_check_done_a: assert property ($fell(data_req) |-> ##2 done)
		else $error("disable did not end two cycles after its sector");
	done_status_a: assert property (done |-> (status == 8'h50 && error == 8'h00)
		|| (status == 8'h51 && error == 8'h04))
		else $error("bad ending status or error");
	done_busy_a: assert property (done |-> !busy && $past(busy))
		else $error("busy not released after done");
	unprepared_abort_a: assert property (done && cur_reg == spdp_pkg::OP_ERASE_UNIT
		&& prev_reg != spdp_pkg::OP_ERASE_PREP |-> error == 8'h04)
		else $error("unprepared erase was not refused");
	cover property (done && cur_reg == spdp_pkg::OP_DISABLE_PW && error == 8'h00);
	cover property (done && cur_reg == spdp_pkg::OP_ERASE_UNIT && error == 8'h00);
	cover property (done && status[0]);
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [255:0] UPW = {8{32'h0123abcd}};
	localparam logic [255:0] MPW = {8{32'h5a5a0f0f}};
	logic         ref_clk_i;
	logic         srst_i = 1'b1;
	logic         req_i = 1'b0;
	logic         req_master_i = 1'b0;
	logic         lock_enabled_i = 1'b1;
	logic         frozen_i = 1'b0;
	logic [7:0]   req_code_i = 8'h00;
	logic [255:0] req_pw_i = 256'h0;
	logic         ack_o;
	logic         aborted_o;
	logic         lock_clear_o;
	logic         erase_start_o;
	logic         prepared_o;
	logic [7:0]   status_o;
	int           fails = 0;
	int           total_checks = 0;
	int           clr_count = 0;
	int           erase_count = 0;
	spdp_if link ();
	spdp_device u_spdp_device (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .link(link), .lock_enabled_i(lock_enabled_i),
		.frozen_i(frozen_i), .user_pw_i(UPW), .master_pw_i(MPW), .lock_clear_o(lock_clear_o),
		.erase_start_o(erase_start_o), .prepared_o(prepared_o));
	spdp_host u_spdp_host (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .link(link), .req_i(req_i), .req_code_i(req_code_i),
		.req_master_i(req_master_i), .req_pw_i(req_pw_i), .ack_o(ack_o), .aborted_o(aborted_o), .status_o(status_o));
	spdp_monitor u_spdp_monitor (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .frozen_i(frozen_i), .cmd_valid(link.cmd_valid),
		.cmd_code(link.cmd_code), .data_req(link.data_req), .data_valid(link.data_valid), .data_word(link.data_word),
		.done(link.done), .status(link.status), .error(link.error), .busy(link.busy));
	// Free-running 100 MHz clock.
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// The unlock and erase pulses last one cycle, so each kind is counted as it comes.
	always @(posedge ref_clk_i)
	begin
		if (lock_clear_o === 1'b1)
			clr_count <= clr_count + 1;
		if (erase_start_o === 1'b1)
			erase_count <= erase_count + 1;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One command through the host end; the wait is bounded so a hang ends the run.
	// Expected events are {unlock, erase}; a count that moved during the command means the pulse came.
	task automatic run(input logic [7:0] code, input logic sel, input logic [255:0] pw, input logic ab,
		input logic [1:0] ev);
		int n;
		int clr0;
		int erase0;
		@(negedge ref_clk_i);
		req_code_i = code;
		req_master_i = sel;
		req_pw_i = pw;
		req_i = 1'b1;
		clr0 = clr_count;
		erase0 = erase_count;
		@(negedge ref_clk_i);
		req_i = 1'b0;
		n = 0;
		while (ack_o !== 1'b1 && n < 400)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n == 400)
		begin
			fails++;
			$display("ERROR %0t no acknowledge", $time);
			test_done();
		end
		else
		begin
			check(status_o, ab ? 8'h51 : 8'h50);
			check({7'h00, aborted_o}, {7'h00, ab});
			check({6'h00, clr_count != clr0, erase_count != erase0}, {6'h00, ev});
		end
	endtask
	// Main sequence of commands and expected endings.
	initial
	begin
		repeat (6) @(negedge ref_clk_i);
		srst_i = 1'b0;
		run(spdp_pkg::OP_DISABLE_PW, 1'b0, UPW, 1'b0, 2'b10);
		run(spdp_pkg::OP_DISABLE_PW, 1'b1, MPW, 1'b0, 2'b10);
		run(spdp_pkg::OP_DISABLE_PW, 1'b1, MPW, 1'b0, 2'b10);
		run(spdp_pkg::OP_DISABLE_PW, 1'b0, MPW, 1'b1, 2'b00);
		run(spdp_pkg::OP_DISABLE_PW, 1'b1, UPW, 1'b1, 2'b00);
		lock_enabled_i = 1'b0;
		run(spdp_pkg::OP_DISABLE_PW, 1'b0, UPW, 1'b1, 2'b00);
		lock_enabled_i = 1'b1;
		run(spdp_pkg::OP_ERASE_PREP, 1'b0, UPW, 1'b0, 2'b00);
		check({7'h00, prepared_o}, 8'h01);
		run(spdp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b0, 2'b01);
		check({7'h00, prepared_o}, 8'h00);
		run(spdp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 2'b00);
		run(spdp_pkg::OP_ERASE_PREP, 1'b0, UPW, 1'b0, 2'b00);
		run(spdp_pkg::OP_DISABLE_PW, 1'b0, UPW, 1'b0, 2'b10);
		check({7'h00, prepared_o}, 8'h00);
		run(spdp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 2'b00);
		frozen_i = 1'b1;
		run(spdp_pkg::OP_DISABLE_PW, 1'b0, UPW, 1'b1, 2'b00);
		run(spdp_pkg::OP_ERASE_PREP, 1'b0, UPW, 1'b1, 2'b00);
		check({7'h00, prepared_o}, 8'h00);
		run(spdp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 2'b00);
		test_done();
	end
endmodule
`default_nettype wire
